/* logic/radio_packet_regs.vh */
// constants for the radio packet handler: field encodings, seeds, fixed bytes
// assumes inclusion by radio_packet_handler.v only
`ifndef RADIO_PACKET_REGS_VH
`define RADIO_PACKET_REGS_VH

// length mode field encodings
`define LEN_FIXED 2'h0
`define LEN_VAR 2'h1
`define LEN_INF 2'h2
// sync mode values that double the sync word
`define SYNC_DBL_A 3'h3
`define SYNC_DBL_B 3'h7
// address check mode encodings
`define ADR_OFF 2'h0
`define ADR_ZERO 2'h2
`define ADR_BOTH 2'h3
`define ADR_BCAST0 8'h00
`define ADR_BCAST1 8'hFF
`define INF_ADR_MARK 8'hFF
// after-receive state value that stays in receive
`define AFTER_RX_STAY 2'h3
// fixed patterns and seeds
`define PREAMBLE_BYTE 8'hAA
`define PN9_SEED 9'h1FF
`define CRC_SEED 16'hFFFF
`define CRC_POLY 16'h8005
`define CRC_RESIDUE 16'h0000
`define CNT_MAX 8'hFF
// transmit states
`define TX_IDLE 3'h0
`define TX_PRE 3'h1
`define TX_SYNC 3'h2
`define TX_DATA 3'h3
`define TX_CRC 3'h4
`define TX_UNDER 3'h5
// receive states
`define RX_IDLE 3'h0
`define RX_HUNT 3'h1
`define RX_BODY 3'h2
`define RX_CRC 3'h3
`define RX_STAT1 3'h4
`define RX_STAT2 3'h5

`endif

/* logic/radio_packet_handler.v */
// packet framer/deframer at byte level between FIFOs and the modem
// assumes one clock; all inputs come from logic on clk_sys; config changed only in idle
`timescale 1ns/1ps
`include "radio_packet_regs.vh"

module radio_packet_handler (
    input wire clk_sys,
    input wire reset_n,
    input wire tx_start,
    input wire rx_start,
    input wire radio_off,
    input wire tx_fifo_flush_command,
    input wire whitening_enable,
    input wire crc_enable,
    input wire crc_fail_flush,
    input wire status_append_enable,
    input wire [1:0] length_mode,
    input wire [1:0] address_check_mode,
    input wire [1:0] after_rx_state,
    input wire [2:0] sync_mode,
    input wire [7:0] preamble_bytes,
    input wire [7:0] sync_word_high,
    input wire [7:0] sync_word_low,
    input wire [7:0] packet_length_limit,
    input wire [7:0] node_address,
    input wire [7:0] rssi_value,
    input wire [6:0] link_quality_value,
    input wire [7:0] txf_data,
    input wire txf_empty,
    output reg txf_pop_r,
    output reg [7:0] mod_data_r,
    output reg mod_valid_r,
    input wire mod_ready,
    input wire rx_sync,
    input wire rx_valid,
    input wire [7:0] rx_data,
    output reg [7:0] rxf_data_r,
    output reg rxf_write_r,
    output reg rxf_flush_r,
    output reg tx_underflow_state_r,
    output reg tx_done_r,
    output reg rx_done_r,
    output reg rx_restart_r,
    output reg crc_ok_r
);

// ************************************************************
// whitening and CRC helpers
// ************************************************************
function [8:0] pn_adv;
    input [8:0] p;
    integer i;
    reg [8:0] q;
    begin
        q = p;
        for (i = 0; i < 8; i = i + 1) begin
            q = {q[0] ^ q[5], q[8:1]};
        end
        pn_adv = q;
    end
endfunction

function [7:0] pn_mask;
    input [8:0] p;
    integer i;
    reg [8:0] q;
    reg [7:0] m;
    begin
        q = p;
        m = 8'h00;
        for (i = 0; i < 8; i = i + 1) begin
            m[i] = q[0];
            q = {q[0] ^ q[5], q[8:1]};
        end
        pn_mask = m;
    end
endfunction

function [15:0] crc_byte;
    input [15:0] c;
    input [7:0] d;
    integer i;
    reg [15:0] q;
    begin
        q = c;
        for (i = 0; i < 8; i = i + 1) begin
            if (q[15] ^ d[7 - i]) begin
                q = {q[14:0], 1'b0} ^ `CRC_POLY;
            end else begin
                q = {q[14:0], 1'b0};
            end
        end
        crc_byte = q;
    end
endfunction

// ************************************************************
// transmit framer
// ************************************************************
reg [2:0] tx_st_r;
reg [7:0] pre_cnt_r;
reg [1:0] sidx_r;
reg [7:0] tx_cnt_r;
reg [7:0] tx_len_r;
reg tx_first_r;
reg [8:0] pn_tx_r;
reg [15:0] crc_tx_r;
reg [7:0] tail_r;
reg tail_v_r;
reg eng_valid;
reg [7:0] eng_data;

wire [7:0] tx_mask = whitening_enable ? pn_mask(pn_tx_r) : 8'h00;
wire push = eng_valid & ~tail_v_r;
wire dbl_sync = (sync_mode == `SYNC_DBL_A) || (sync_mode == `SYNC_DBL_B);
wire [7:0] tx_cnt_inc = tx_cnt_r + 8'h01;
wire [7:0] tx_target = (length_mode == `LEN_VAR) ? tx_len_r : packet_length_limit;
wire tx_end = (length_mode != `LEN_INF) && (tx_cnt_inc == tx_target);

always @* begin
    eng_valid = 1'b0;
    eng_data = `PREAMBLE_BYTE;
    case (tx_st_r)
        `TX_PRE: begin
            eng_valid = 1'b1;
        end
        `TX_SYNC: begin
            eng_valid = 1'b1;
            eng_data = sidx_r[0] ? sync_word_low : sync_word_high;
        end
        `TX_DATA: begin
            eng_valid = ~txf_empty & ~txf_pop_r;
            eng_data = txf_data ^ tx_mask;
        end
        `TX_CRC: begin
            eng_valid = 1'b1;
            eng_data = (sidx_r[0] ? crc_tx_r[7:0] : crc_tx_r[15:8]) ^ tx_mask;
        end
        default: begin
            eng_valid = 1'b0;
        end
    endcase
end

always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
        tx_st_r <= `TX_IDLE;
        pre_cnt_r <= 8'h00;
        sidx_r <= 2'h0;
        tx_cnt_r <= 8'h00;
        tx_len_r <= 8'h00;
        tx_first_r <= 1'b0;
        pn_tx_r <= `PN9_SEED;
        crc_tx_r <= `CRC_SEED;
        txf_pop_r <= 1'b0;
        tx_done_r <= 1'b0;
        tx_underflow_state_r <= 1'b0;
    end else begin
        txf_pop_r <= 1'b0;
        tx_done_r <= 1'b0;
        if (radio_off && tx_st_r != `TX_UNDER) begin
            tx_st_r <= `TX_IDLE;
        end else begin
            case (tx_st_r)
                `TX_IDLE: begin
                    if (tx_start) begin
                        tx_st_r <= `TX_PRE;
                        pre_cnt_r <= 8'h00;
                    end
                end
                `TX_PRE: begin
                    if (push) begin
                        if (pre_cnt_r != `CNT_MAX) begin
                            pre_cnt_r <= pre_cnt_r + 8'h01;
                        end
                        // an empty FIFO keeps the preamble going
                        if ({1'b0, pre_cnt_r} + 9'h001 >= {1'b0, preamble_bytes} && !txf_empty) begin
                            tx_st_r <= `TX_SYNC;
                            sidx_r <= 2'h0;
                        end
                    end
                end
                `TX_SYNC: begin
                    if (push) begin
                        sidx_r <= sidx_r + 2'h1;
                        if (sidx_r == (dbl_sync ? 2'h3 : 2'h1)) begin
                            tx_st_r <= `TX_DATA;
                            tx_cnt_r <= 8'h00;
                            tx_first_r <= (length_mode == `LEN_VAR);
                            pn_tx_r <= `PN9_SEED;
                            crc_tx_r <= `CRC_SEED;
                        end
                    end
                end
                `TX_DATA: begin
                    if (txf_empty && !txf_pop_r) begin
                        tx_st_r <= `TX_UNDER;
                        tx_underflow_state_r <= 1'b1;
                    end else if (push) begin
                        txf_pop_r <= 1'b1;
                        crc_tx_r <= crc_byte(crc_tx_r, txf_data);
                        pn_tx_r <= whitening_enable ? pn_adv(pn_tx_r) : pn_tx_r;
                        if (tx_first_r) begin
                            tx_len_r <= txf_data;
                            tx_first_r <= 1'b0;
                        end else begin
                            tx_cnt_r <= tx_cnt_inc;
                            if (tx_end) begin
                                sidx_r <= 2'h0;
                                if (crc_enable) begin
                                    tx_st_r <= `TX_CRC;
                                end else begin
                                    tx_st_r <= `TX_IDLE;
                                    tx_done_r <= 1'b1;
                                end
                            end
                        end
                    end
                end
                `TX_CRC: begin
                    if (push) begin
                        sidx_r <= sidx_r + 2'h1;
                        pn_tx_r <= whitening_enable ? pn_adv(pn_tx_r) : pn_tx_r;
                        if (sidx_r[0]) begin
                            tx_st_r <= `TX_IDLE;
                            tx_done_r <= 1'b1;
                        end
                    end
                end
                `TX_UNDER: begin
                    // further FIFO writes do not restart; only the flush does
                    if (tx_fifo_flush_command) begin
                        tx_st_r <= `TX_IDLE;
                        tx_underflow_state_r <= 1'b0;
                    end
                end
                default: begin
                    tx_st_r <= `TX_IDLE;
                end
            endcase
        end
    end
end

// ************************************************************
// two-entry buffer toward the modulator
// ************************************************************
// head is the output flop so a stall holds data without loss
always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
        mod_data_r <= 8'h00;
        mod_valid_r <= 1'b0;
        tail_r <= 8'h00;
        tail_v_r <= 1'b0;
    end else if (mod_valid_r && mod_ready) begin
        if (tail_v_r) begin
            mod_data_r <= tail_r;
            tail_v_r <= 1'b0;
        end else begin
            mod_valid_r <= push;
            mod_data_r <= eng_data;
        end
    end else if (push) begin
        if (!mod_valid_r) begin
            mod_data_r <= eng_data;
            mod_valid_r <= 1'b1;
        end else begin
            tail_r <= eng_data;
            tail_v_r <= 1'b1;
        end
    end
end

// ************************************************************
// receive deframer
// ************************************************************
reg [2:0] rx_st_r;
reg [7:0] rx_cnt_r;
reg [7:0] rx_len_r;
reg rx_first_r;
reg adr_pend_r;
reg crc_half_r;
reg [8:0] pn_rx_r;
reg [15:0] crc_rx_r;
reg [7:0] pend_r;
reg pend_v_r;

wire [7:0] rxd = rx_data ^ (whitening_enable ? pn_mask(pn_rx_r) : 8'h00);
wire [15:0] crc_rx_nxt = crc_byte(crc_rx_r, rxd);
wire [7:0] rx_cnt_inc = rx_cnt_r + 8'h01;
wire [7:0] rx_target = (length_mode == `LEN_VAR) ? rx_len_r : packet_length_limit;
wire rx_end = (length_mode != `LEN_INF) && (rx_cnt_inc == rx_target);
wire adr_match = (rxd == node_address) ||
    ((address_check_mode == `ADR_ZERO || address_check_mode == `ADR_BOTH) && rxd == `ADR_BCAST0) ||
    (address_check_mode == `ADR_BOTH && rxd == `ADR_BCAST1);
wire rx_next_hunt = (after_rx_state == `AFTER_RX_STAY);
wire crc_pass = (crc_rx_nxt == `CRC_RESIDUE);

always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
        rx_st_r <= `RX_IDLE;
        rx_cnt_r <= 8'h00;
        rx_len_r <= 8'h00;
        rx_first_r <= 1'b0;
        adr_pend_r <= 1'b0;
        crc_half_r <= 1'b0;
        pn_rx_r <= `PN9_SEED;
        crc_rx_r <= `CRC_SEED;
        pend_r <= 8'h00;
        pend_v_r <= 1'b0;
        rxf_data_r <= 8'h00;
        rxf_write_r <= 1'b0;
        rxf_flush_r <= 1'b0;
        rx_done_r <= 1'b0;
        rx_restart_r <= 1'b0;
        crc_ok_r <= 1'b1;
    end else begin
        rxf_write_r <= 1'b0;
        rxf_flush_r <= 1'b0;
        rx_done_r <= 1'b0;
        rx_restart_r <= 1'b0;
        if (pend_v_r) begin
            rxf_write_r <= 1'b1;
            rxf_data_r <= pend_r;
            pend_v_r <= 1'b0;
        end
        if (radio_off) begin
            rx_st_r <= `RX_IDLE;
        end else begin
            case (rx_st_r)
                `RX_IDLE: begin
                    if (rx_start) begin
                        rx_st_r <= `RX_HUNT;
                    end
                end
                `RX_HUNT: begin
                    if (rx_sync) begin
                        rx_st_r <= `RX_BODY;
                        rx_cnt_r <= 8'h00;
                        rx_first_r <= (length_mode == `LEN_VAR);
                        adr_pend_r <= (address_check_mode != `ADR_OFF);
                        crc_half_r <= 1'b0;
                        pn_rx_r <= `PN9_SEED;
                        crc_rx_r <= `CRC_SEED;
                    end
                end
                `RX_BODY: begin
                    if (rx_valid) begin
                        pn_rx_r <= whitening_enable ? pn_adv(pn_rx_r) : pn_rx_r;
                        crc_rx_r <= crc_rx_nxt;
                        if (rx_first_r) begin
                            rx_first_r <= 1'b0;
                            rx_len_r <= rxd;
                            if (rxd > packet_length_limit) begin
                                rx_st_r <= `RX_HUNT;
                                rx_restart_r <= 1'b1;
                            end else if (!adr_pend_r) begin
                                rxf_write_r <= 1'b1;
                                rxf_data_r <= rxd;
                            end
                        end else if (adr_pend_r && !adr_match) begin
                            rx_st_r <= `RX_HUNT;
                            rx_restart_r <= 1'b1;
                        end else begin
                            rx_cnt_r <= rx_cnt_inc;
                            adr_pend_r <= 1'b0;
                            rxf_write_r <= 1'b1;
                            // held length byte or marker goes first, address follows
                            if (adr_pend_r && length_mode == `LEN_VAR) begin
                                rxf_data_r <= rx_len_r;
                                pend_r <= rxd;
                                pend_v_r <= 1'b1;
                            end else if (adr_pend_r && length_mode == `LEN_INF) begin
                                rxf_data_r <= `INF_ADR_MARK;
                                pend_r <= rxd;
                                pend_v_r <= 1'b1;
                            end else begin
                                rxf_data_r <= rxd;
                            end
                            if (rx_end) begin
                                if (crc_enable) begin
                                    rx_st_r <= `RX_CRC;
                                end else begin
                                    crc_ok_r <= 1'b1;
                                    if (status_append_enable) begin
                                        rx_st_r <= `RX_STAT1;
                                    end else begin
                                        rx_st_r <= rx_next_hunt ? `RX_HUNT : `RX_IDLE;
                                        rx_done_r <= 1'b1;
                                    end
                                end
                            end
                        end
                    end
                end
                `RX_CRC: begin
                    if (rx_valid) begin
                        pn_rx_r <= whitening_enable ? pn_adv(pn_rx_r) : pn_rx_r;
                        crc_rx_r <= crc_rx_nxt;
                        crc_half_r <= 1'b1;
                        if (crc_half_r) begin
                            crc_ok_r <= crc_pass;
                            if (!crc_pass && crc_fail_flush) begin
                                rxf_flush_r <= 1'b1;
                                rx_st_r <= rx_next_hunt ? `RX_HUNT : `RX_IDLE;
                                rx_done_r <= 1'b1;
                            end else if (status_append_enable) begin
                                rx_st_r <= `RX_STAT1;
                            end else begin
                                rx_st_r <= rx_next_hunt ? `RX_HUNT : `RX_IDLE;
                                rx_done_r <= 1'b1;
                            end
                        end
                    end
                end
                `RX_STAT1: begin
                    if (!pend_v_r) begin
                        rxf_write_r <= 1'b1;
                        rxf_data_r <= rssi_value;
                        rx_st_r <= `RX_STAT2;
                    end
                end
                `RX_STAT2: begin
                    rxf_write_r <= 1'b1;
                    rxf_data_r <= {crc_ok_r, link_quality_value};
                    rx_st_r <= rx_next_hunt ? `RX_HUNT : `RX_IDLE;
                    rx_done_r <= 1'b1;
                end
                default: begin
                    rx_st_r <= `RX_IDLE;
                end
            endcase
        end
    end
end

endmodule

/* tb/radio_packet_handler_chk.sv */
// port checks for the packet handler
// assumes the bind below and a single clock
`timescale 1ns/1ps
module radio_packet_handler_chk (
    input wire clk_sys,
    input wire reset_n,
    input wire crc_enable,
    input wire txf_empty,
    input wire mod_ready,
    input wire tx_fifo_flush_command,
    input wire txf_pop_r,
    input wire [7:0] mod_data_r,
    input wire mod_valid_r,
    input wire rxf_flush_r,
    input wire rxf_write_r,
    input wire tx_underflow_state_r,
    input wire rx_done_r,
    input wire crc_ok_r
);
    // ****************
    // properties
    // ****************
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);
    sequence stall_s;
        mod_valid_r && !mod_ready;
    endsequence
    sequence hold_s;
        mod_valid_r && $stable(mod_data_r);
    endsequence
    mod_hold_a: assert property (stall_s |=> hold_s) else $error("modulator byte lost in stall");
    pop_data_a: assert property (txf_pop_r |-> !$past(txf_empty)) else $error("pop from empty fifo");
    pop_pulse_a: assert property (txf_pop_r |=> !txf_pop_r) else $error("pop longer than a cycle");
    under_stay_a: assert property (tx_underflow_state_r && !tx_fifo_flush_command |=> tx_underflow_state_r)
        else $error("underflow left without flush");
    under_quiet_a: assert property (tx_underflow_state_r && $past(tx_underflow_state_r) |-> !txf_pop_r)
        else $error("pop during underflow");
    flush_clean_a: assert property (rxf_flush_r |=> !rxf_write_r [*2]) else $error("write after flush");
    flush_bad_a: assert property (rxf_flush_r |-> ##[0:2] !crc_ok_r) else $error("flush with crc ok");
    crc_off_a: assert property (rx_done_r && !crc_enable |-> ##[0:2] crc_ok_r) else $error("crc off not ok");
    reset_quiet_a: assert property ($rose(reset_n) |-> crc_ok_r && !mod_valid_r) else $error("bad reset outputs");
    cover property (tx_underflow_state_r);
endmodule
bind radio_packet_handler radio_packet_handler_chk u_chk (.clk_sys, .reset_n, .crc_enable, .txf_empty,
    .mod_ready, .tx_fifo_flush_command, .txf_pop_r, .mod_data_r, .mod_valid_r, .rxf_flush_r,
    .rxf_write_r, .tx_underflow_state_r, .rx_done_r, .crc_ok_r);

/* tb/tx_fifo_model.sv */
// host side TX FIFO, first word falls through
// assumes pushes and flushes arrive between clock edges
`timescale 1ns/1ps
module tx_fifo_model (
    input wire clk_sys,
    input wire reset_n,
    input wire push,
    input wire [7:0] push_data,
    input wire flush,
    input wire txf_pop_r,
    output logic [7:0] txf_data,
    output logic txf_empty
);
    // ****************
    // storage
    // ****************
    logic [7:0] mem [0:15];
    logic [3:0] wp;
    logic [3:0] rp;
    logic [4:0] cnt;
    logic [7:0] last_r;
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            wp <= 4'h0;
            rp <= 4'h0;
            cnt <= 5'h00;
            last_r <= 8'h00;
        end else if (flush) begin
            rp <= wp;
            cnt <= 5'h00;
        end else begin
            if (push) begin
                mem[wp] <= push_data;
                wp <= wp + 4'h1;
            end
            if (txf_pop_r) begin
                last_r <= mem[rp];
                rp <= rp + 4'h1;
            end
            cnt <= cnt + {4'h0, push} - {4'h0, txf_pop_r};
        end
    end
    // empty head shows the inverse of the last word so stale data cannot pass
    assign txf_empty = (cnt == 5'h00);
    assign txf_data = txf_empty ? ~last_r : mem[rp];
endmodule

/* tb/test_radio_packet_handler.sv */
// self-checking bench for the packet handler
// assumes the TX FIFO model and the bound checker
`timescale 1ns/1ps
module test_radio_packet_handler;
    logic clk_sys = 1'b0, reset_n = 1'b0, tx_start = 1'b0, rx_start = 1'b0, radio_off = 1'b0;
    logic tx_fifo_flush_command = 1'b0, whitening_enable = 1'b0, crc_enable = 1'b0;
    logic crc_fail_flush = 1'b0, status_append_enable = 1'b0, mod_ready = 1'b0;
    logic rx_sync = 1'b0, rx_valid = 1'b0, push = 1'b0;
    logic [1:0] length_mode = 2'h0, address_check_mode = 2'h0, after_rx_state = 2'h0;
    logic [2:0] sync_mode = 3'h0;
    logic [7:0] preamble_bytes = 8'h02, sync_word_high = 8'hD3, sync_word_low = 8'h91;
    logic [7:0] packet_length_limit = 8'h02, node_address = 8'h42, rssi_value = 8'h00;
    logic [7:0] rx_data = 8'h00, push_data = 8'h00, txf_data, mod_data_r, rxf_data_r;
    logic [6:0] link_quality_value = 7'h00;
    logic txf_empty, txf_pop_r, mod_valid_r, rxf_write_r, rxf_flush_r;
    logic tx_underflow_state_r, tx_done_r, rx_done_r, rx_restart_r, crc_ok_r;
    logic s_done = 1'b0, s_rdone = 1'b0, s_under = 1'b0, s_flush = 1'b0, s_rst = 1'b0;
    logic [7:0] txq[$], rxq[$];
    int failures = 0, n_checks = 0, cyc = 0;
    radio_packet_handler u_dut (.clk_sys, .reset_n, .tx_start, .rx_start, .radio_off,
        .tx_fifo_flush_command, .whitening_enable, .crc_enable, .crc_fail_flush, .status_append_enable,
        .length_mode, .address_check_mode, .after_rx_state, .sync_mode, .preamble_bytes,
        .sync_word_high, .sync_word_low, .packet_length_limit, .node_address, .rssi_value,
        .link_quality_value, .txf_data, .txf_empty, .txf_pop_r, .mod_data_r, .mod_valid_r, .mod_ready,
        .rx_sync, .rx_valid, .rx_data, .rxf_data_r, .rxf_write_r, .rxf_flush_r, .tx_underflow_state_r,
        .tx_done_r, .rx_done_r, .rx_restart_r, .crc_ok_r);
    tx_fifo_model u_fifo (.clk_sys, .reset_n, .push, .push_data, .flush(tx_fifo_flush_command),
        .txf_pop_r, .txf_data, .txf_empty);
    // ****************
    // clock, monitors, helpers
    // ****************
    initial forever #12.5 clk_sys = ~clk_sys;
    // stalls fill the two-entry buffer
    always @(negedge clk_sys) mod_ready <= (cyc % 4) != 3;
    always @(posedge clk_sys) begin
        cyc++;
        if (mod_valid_r === 1'b1 && mod_ready)
            txq.push_back(mod_data_r);
        if (rxf_write_r === 1'b1)
            rxq.push_back(rxf_data_r);
        s_done = s_done | (tx_done_r === 1'b1);
        s_rdone = s_rdone | (rx_done_r === 1'b1);
        s_under = s_under | (tx_underflow_state_r === 1'b1);
        s_flush = s_flush | (rxf_flush_r === 1'b1);
        s_rst = s_rst | (rx_restart_r === 1'b1);
        if (cyc == 30000) begin
            failures++;
            test_done();
        end
    end
    task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic pulse(ref logic s);
        @(negedge clk_sys) s = 1'b1;
        @(negedge clk_sys) s = 1'b0;
    endtask
    task automatic put(input logic [7:0] b);
        push_data = b;
        pulse(push);
    endtask
    task automatic rxb(input logic [7:0] b);
        repeat (3) @(negedge clk_sys);
        rx_data = b;
        pulse(rx_valid);
    endtask
    task automatic wait_flag(ref logic f);
        for (int i = 0; i < 3000 && !f; i++) @(negedge clk_sys);
        check("completion", f, 1'b1);
        repeat (12) @(negedge clk_sys);
    endtask
    task automatic cfg(input logic [1:0] lm, input logic [3:0] f, input logic [1:0] am, input logic [7:0] n);
        length_mode = lm;
        {whitening_enable, crc_enable, crc_fail_flush, status_append_enable} = f;
        address_check_mode = am;
        packet_length_limit = n;
        txq.delete();
        rxq.delete();
        {s_done, s_rdone, s_under, s_flush, s_rst} = 5'h00;
    endtask
    function automatic logic [7:0] white(input int n);
        logic [8:0] s;
        logic [7:0] m;
        s = 9'h1FF;
        for (int i = 0; i < n * 8 + 8; i++) begin
            if (i >= n * 8) m[i % 8] = s[0];
            s = {s[0] ^ s[5], s[8:1]};
        end
        return m;
    endfunction
    function automatic logic [15:0] crc16(input logic [15:0] c, input logic [7:0] d);
        for (int i = 7; i >= 0; i--) c = (c[15] ^ d[i]) ? {c[14:0], 1'b0} ^ 16'h8005 : {c[14:0], 1'b0};
        return c;
    endfunction
    // ****************
    // scenarios
    // ****************
    task automatic t_tx_plain;
        logic [7:0] e[6] = '{8'hD3, 8'h91, 8'hD3, 8'h91, 8'h42, 8'h7E};
        int i;
        for (int m = 0; m < 2; m++) begin
            cfg(2'h0, 4'h0, 2'h0, 8'h02);
            sync_mode = m ? 3'h7 : 3'h3;
            pulse(tx_start);
            repeat (40) @(negedge clk_sys);
            put(8'h42);
            put(8'h7E);
            wait_flag(s_done);
            i = 0;
            while (i < txq.size() && txq[i] === 8'hAA) i++;
            check("preamble run", i > 2, 1'b1);
            check("tx count", txq.size(), i + 6);
            foreach (e[k]) check("tx byte", txq[i + k], e[k]);
        end
    endtask
    task automatic t_tx_crc;
        logic [15:0] c;
        logic [7:0] e[4];
        int n;
        cfg(2'h0, 4'hC, 2'h0, 8'h02);
        sync_mode = 3'h0;
        c = crc16(crc16(16'hFFFF, 8'h5A), 8'hC3);
        e = '{8'h5A ^ white(0), 8'hC3 ^ white(1), c[15:8] ^ white(2), c[7:0] ^ white(3)};
        put(8'h5A);
        put(8'hC3);
        pulse(tx_start);
        wait_flag(s_done);
        n = txq.size();
        check("sync end", txq[n - 5], 8'h91);
        foreach (e[k]) check("white crc", txq[n - 4 + k], e[k]);
    endtask
    task automatic t_underflow;
        cfg(2'h0, 4'h0, 2'h0, 8'h03);
        put(8'h11);
        pulse(tx_start);
        wait_flag(s_under);
        put(8'h22);
        repeat (20) @(negedge clk_sys);
        check("still under", tx_underflow_state_r, 1'b1);
        pulse(tx_fifo_flush_command);
        @(negedge clk_sys);
        check("under cleared", tx_underflow_state_r, 1'b0);
    endtask
    task automatic t_rx_ok;
        cfg(2'h1, 4'h1, 2'h2, 8'h08);
        rssi_value = 8'hC5;
        link_quality_value = 7'h2B;
        pulse(rx_start);
        pulse(rx_sync);
        rxb(8'h02);
        rxb(8'h00);
        rxb(8'h5C);
        wait_flag(s_rdone);
        check("rx count", rxq.size(), 5);
        check("rx addr", rxq[1], 8'h00);
        check("rssi byte", rxq[3], 8'hC5);
        check("status byte", rxq[4], 8'hAB);
    endtask
    task automatic t_rx_filter;
        logic [1:0] am[4] = '{2'h1, 2'h3, 2'h1, 2'h1};
        logic [7:0] ad[4] = '{8'h00, 8'hFF, 8'h42, 8'h5C};
        logic [7:0] ln[4] = '{8'h02, 8'h02, 8'h09, 8'h42};
        foreach (am[k]) begin
            cfg(k == 3 ? 2'h2 : 2'h1, 4'h1, am[k], 8'h08);
            pulse(rx_start);
            pulse(rx_sync);
            rxb(ln[k]);
            rxb(ad[k]);
            rxb(8'h5C);
            repeat (30) @(negedge clk_sys);
            check("restart", s_rst, !k[0]);
            check("rx kept", rxq.size(), k[0] ? 5 - k / 3 : 0);
            if (k == 3) check("mark", rxq[0], 8'hFF);
        end
        pulse(radio_off);
    endtask
    task automatic t_rx_crc;
        logic [15:0] c;
        c = crc16(16'hFFFF, 8'h33);
        for (int bad = 0; bad < 2; bad++) begin
            cfg(2'h0, 4'hF, 2'h0, 8'h01);
            pulse(rx_start);
            pulse(rx_sync);
            rxb(8'h33 ^ white(0));
            rxb(c[15:8] ^ white(1) ^ bad[7:0]);
            rxb(c[7:0] ^ white(2));
            wait_flag(s_rdone);
            check("rx data", rxq[0], 8'h33);
            check("flushed", s_flush, bad[0]);
            check("crc flag", crc_ok_r, !bad[0]);
            check("rx count", rxq.size(), bad ? 1 : 3);
        end
    endtask
    task automatic test_done;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (16) @(negedge clk_sys);
        reset_n = 1'b1;
        check("reset crc", crc_ok_r, 1'b1);
        t_tx_plain();
        t_tx_crc();
        t_underflow();
        t_rx_ok();
        t_rx_filter();
        t_rx_crc();
        test_done();
    end
endmodule
